/* File: serial_eeprom_id_loader.v */
// Purpose: Loads vendor and sub-vendor words from a serial EEPROM after reset,
//          then hands the four EEPROM lines to software.
// Assumes: All inputs synchronous to sys_clk.
// Notes:   Control bits are plain ports; no register bus.
//          The select pin floats for four cycles after reset so its pull-up can be sensed.
//          Manual bits take effect one cycle later and are ignored until the load ends.
//          Identification words hold their value until the next reset.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_loader_regs.vh"

module serial_eeprom_id_loader #(
    parameter HALF_CYCLES = `HALF_DIV_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire        man_clock_bit,
    input  wire        man_select_bit,
    input  wire        man_write_bit,
    input  wire        eeprom_select_in,
    input  wire        eeprom_read_data,
    output reg         eeprom_serial_clock,
    output reg         eeprom_select_out,
    output reg         eeprom_select_oe,
    output reg         eeprom_write_data,
    output reg         man_read_bit_ff,
    output reg  [15:0] vendor_id_ff,
    output reg  [15:0] subsys_vendor_id_ff,
    output reg         eeprom_present_ff,
    output reg         load_done_ff
);

    // ------------------------------------------------------------------------
    // Load sequencer states.
    // ------------------------------------------------------------------------
    localparam ST_SENSE  = 5'h01;
    localparam ST_VENDOR = 5'h02;
    localparam ST_WAIT_V = 5'h04;
    localparam ST_WAIT_S = 5'h08;
    localparam ST_MANUAL = 5'h10;

    // ------------------------------------------------------------------------
    // Sequencer, reader and pin source wiring.
    // ------------------------------------------------------------------------
    reg  [4:0]  state_ff;
    reg  [4:0]  nxt_state;
    reg  [1:0]  sense_cnt_ff;
    reg         rd_start;
    reg  [5:0]  rd_addr;
    wire        rd_sclk;
    wire        rd_sel;
    wire        rd_wbit;
    wire [15:0] rd_word;
    wire        rd_done;
    reg         nxt_serial_clock;
    reg         nxt_select_out;
    reg         nxt_select_oe;
    reg         nxt_write_data;

    // ------------------------------------------------------------------------
    // Word reader with the divided serial clock.
    // ------------------------------------------------------------------------
    eeprom_word_reader #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_reader (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .start        (rd_start),
        .word_addr    (rd_addr),
        .read_bit     (eeprom_read_data),
        .sclk_ff      (rd_sclk),
        .select_ff    (rd_sel),
        .write_bit_ff (rd_wbit),
        .word_ff      (rd_word),
        .done_ff      (rd_done)
    );

    // ------------------------------------------------------------------------
    // Load sequencer.
    // ------------------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        rd_start  = 1'b0;
        rd_addr   = `VENDOR_WORD_ADDR;
        case (state_ff)
            ST_SENSE: begin
                if (sense_cnt_ff == 2'h3) begin
                    nxt_state = eeprom_select_in ? ST_VENDOR : ST_MANUAL;
                end
            end
            ST_VENDOR: begin
                rd_start  = 1'b1;
                nxt_state = ST_WAIT_V;
            end
            ST_WAIT_V: begin
                if (rd_done) begin
                    rd_start  = 1'b1;
                    rd_addr   = `SUBSYS_WORD_ADDR;
                    nxt_state = ST_WAIT_S;
                end
            end
            ST_WAIT_S: begin
                if (rd_done) begin
                    nxt_state = ST_MANUAL;
                end
            end
            ST_MANUAL: begin
                nxt_state = ST_MANUAL;
            end
            default: begin
                nxt_state = ST_SENSE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer state and sense counter.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff     <= ST_SENSE;
            sense_cnt_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_SENSE) begin
                sense_cnt_ff <= sense_cnt_ff + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Presence flag, taken from the select pin while it is undriven.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            eeprom_present_ff <= 1'b0;
        end else if (state_ff == ST_SENSE && sense_cnt_ff == 2'h3) begin
            eeprom_present_ff <= eeprom_select_in;
        end
    end

    // ------------------------------------------------------------------------
    // Identification words, each stored as its transfer completes.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            vendor_id_ff        <= `VENDOR_ID_RESET;
            subsys_vendor_id_ff <= `SUBSYS_ID_RESET;
        end else begin
            if (state_ff == ST_WAIT_V && rd_done) begin
                vendor_id_ff <= rd_word;
            end
            if (state_ff == ST_WAIT_S && rd_done) begin
                subsys_vendor_id_ff <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Load done flag and read-data sample.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            load_done_ff    <= 1'b0;
            man_read_bit_ff <= 1'b0;
        end else begin
            man_read_bit_ff <= eeprom_read_data;
            if (nxt_state == ST_MANUAL) begin
                load_done_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin source: sensing floats the select pin, the load lends the pins to
    // the word reader, and the manual phase hands them to software.
    // ------------------------------------------------------------------------
    always @* begin
        nxt_serial_clock = eeprom_serial_clock;
        nxt_select_out   = eeprom_select_out;
        nxt_select_oe    = eeprom_select_oe;
        nxt_write_data   = eeprom_write_data;
        if (nxt_state == ST_MANUAL) begin
            nxt_serial_clock = man_clock_bit;
            nxt_select_out   = man_select_bit;
            nxt_select_oe    = 1'b1;
            nxt_write_data   = man_write_bit;
        end else if (nxt_state == ST_SENSE) begin
            nxt_select_oe    = 1'b0;
        end else begin
            nxt_serial_clock = rd_sclk;
            nxt_select_out   = rd_sel;
            nxt_select_oe    = 1'b1;
            nxt_write_data   = rd_wbit;
        end
    end

    // ------------------------------------------------------------------------
    // Pin registers, so that every pin leaves straight from a flip-flop.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            eeprom_serial_clock <= 1'b0;
            eeprom_select_out   <= 1'b0;
            eeprom_select_oe    <= 1'b0;
            eeprom_write_data   <= 1'b0;
        end else begin
            eeprom_serial_clock <= nxt_serial_clock;
            eeprom_select_out   <= nxt_select_out;
            eeprom_select_oe    <= nxt_select_oe;
            eeprom_write_data   <= nxt_write_data;
        end
    end

endmodule // serial_eeprom_id_loader
`default_nettype wire

/* File: eeprom_loader_regs.vh */
// Purpose: Constants for the serial EEPROM identification loader.
// Assumes: Three-wire serial EEPROM organised as 16-bit words.
// Notes:   Word addresses may be changed per part; the opcode width is fixed by the 9-bit command register.
`ifndef EEPROM_LOADER_REGS_VH
`define EEPROM_LOADER_REGS_VH

// ----------------------------------------------------------------------------
// Serial clock and command format.
// ----------------------------------------------------------------------------
`define CLK_DIV_RATIO      256
`define HALF_DIV_CYCLES    128
`define READ_OPCODE        3'h6
`define OPCODE_BITS        3
`define ADDR_BITS          6
`define DATA_BITS          16

// ----------------------------------------------------------------------------
// Word addresses of the identification words.
// ----------------------------------------------------------------------------
`define VENDOR_WORD_ADDR   6'h00
`define SUBSYS_WORD_ADDR   6'h01

// ----------------------------------------------------------------------------
// Reset values of the identification outputs.
// ----------------------------------------------------------------------------
`define VENDOR_ID_RESET    16'h0000
`define SUBSYS_ID_RESET    16'h0000

`endif

/* File: eeprom_word_reader.v */
// Purpose: Reads one 16-bit word from a serial EEPROM with a divided clock.
// Assumes: Select active high; command bits change at clock rise, data is taken at fall.
// Notes:   One transfer per start strobe.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_loader_regs.vh"

module eeprom_word_reader #(
    parameter HALF_CYCLES = `HALF_DIV_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire        start,
    input  wire [5:0]  word_addr,
    input  wire        read_bit,
    output reg         sclk_ff,
    output reg         select_ff,
    output reg         write_bit_ff,
    output reg  [15:0] word_ff,
    output reg         done_ff
);

    localparam CMD_BITS = `OPCODE_BITS + `ADDR_BITS;

    reg        busy_ff;
    reg [7:0]  div_ff;
    reg [5:0]  bit_ff;
    reg [8:0]  cmd_ff;

    wire half_tick = (div_ff == HALF_CYCLES[7:0] - 8'h01);

    // ------------------------------------------------------------------------
    // Command shift and data capture, one bit per divided clock period.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_ff      <= 1'b0;
            div_ff       <= 8'h00;
            bit_ff       <= 6'h00;
            cmd_ff       <= 9'h000;
            sclk_ff      <= 1'b0;
            select_ff    <= 1'b0;
            write_bit_ff <= 1'b0;
            word_ff      <= 16'h0000;
            done_ff      <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (!busy_ff) begin
                if (start) begin
                    busy_ff      <= 1'b1;
                    select_ff    <= 1'b1;
                    cmd_ff       <= {`READ_OPCODE, word_addr};
                    write_bit_ff <= 1'b0;
                    div_ff       <= 8'h00;
                    bit_ff       <= 6'h00;
                    sclk_ff      <= 1'b0;
                end
            end else if (half_tick) begin
                div_ff  <= 8'h00;
                sclk_ff <= ~sclk_ff;
                if (!sclk_ff) begin
                    if (bit_ff < CMD_BITS[5:0]) begin
                        write_bit_ff <= cmd_ff[8];
                        cmd_ff       <= {cmd_ff[7:0], 1'b0};
                    end else begin
                        write_bit_ff <= 1'b0;
                    end
                end else begin
                    if (bit_ff > CMD_BITS[5:0]) begin
                        word_ff <= {word_ff[14:0], read_bit};
                    end
                    bit_ff <= bit_ff + 6'h01;
                    if (bit_ff == CMD_BITS[5:0] + 6'h10) begin
                        busy_ff   <= 1'b0;
                        select_ff <= 1'b0;
                        done_ff   <= 1'b1;
                    end
                end
            end else begin
                div_ff <= div_ff + 8'h01;
            end
        end
    end

endmodule // eeprom_word_reader
`default_nettype wire

/* File: id_loader_assertions.sv */
// Purpose: Port checks of the EEPROM identification loader.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Bound to every loader instance.
`timescale 1ns/1ps
`default_nettype none
module id_loader_checker #(parameter int HALF_CYCLES = 128) (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        man_clock_bit,
    input wire logic        man_select_bit,
    input wire logic        man_write_bit,
    input wire logic        eeprom_select_in,
    input wire logic        eeprom_read_data,
    input wire logic        eeprom_serial_clock,
    input wire logic        eeprom_select_out,
    input wire logic        eeprom_select_oe,
    input wire logic        eeprom_write_data,
    input wire logic        man_read_bit_ff,
    input wire logic [15:0] vendor_id_ff,
    input wire logic [15:0] subsys_vendor_id_ff,
    input wire logic        eeprom_present_ff,
    input wire logic        load_done_ff
);
    logic [7:0] hi_ff;
    logic [3:0] cyc_ff;
    // ------------------------------------------------------------------
    // Counts of high clock phase and of cycles since reset.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hi_ff  <= 8'h00;
            cyc_ff <= 4'h0;
        end else begin
            hi_ff  <= eeprom_serial_clock ? hi_ff + 8'h01 : 8'h00;
            cyc_ff <= (cyc_ff == 4'hF) ? cyc_ff : cyc_ff + 4'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    clk_half_a: assert property ($fell(eeprom_serial_clock) && !load_done_ff
        |-> hi_ff == HALF_CYCLES) else $error("clock high phase length");
    sel_load_a: assert property (!load_done_ff && eeprom_serial_clock
        |-> eeprom_select_out && eeprom_select_oe) else $error("select during load");
    clk_manual_a: assert property (load_done_ff && $past(load_done_ff)
        |-> eeprom_serial_clock == $past(man_clock_bit)) else $error("manual clock");
    sel_manual_a: assert property (load_done_ff && $past(load_done_ff)
        |-> eeprom_select_oe && eeprom_select_out == $past(man_select_bit))
        else $error("manual select");
    wdat_manual_a: assert property (load_done_ff && $past(load_done_ff)
        |-> eeprom_write_data == $past(man_write_bit)) else $error("manual write");
    rdat_sample_a: assert property (load_done_ff && $past(load_done_ff)
        |-> man_read_bit_ff == $past(eeprom_read_data)) else $error("read sample");
    sense_float_a: assert property (cyc_ff < 4'h4 |-> !eeprom_select_oe)
        else $error("select driven while sensing");
    absent_done_a: assert property (!eeprom_present_ff && cyc_ff == 4'hF
        |-> load_done_ff) else $error("no manual phase without part");
    ids_stable_a: assert property (load_done_ff && $past(load_done_ff)
        |-> $stable(vendor_id_ff) && $stable(subsys_vendor_id_ff)) else $error("ids moved");
endmodule // id_loader_checker
bind serial_eeprom_id_loader id_loader_checker #(.HALF_CYCLES(HALF_CYCLES)) chk_i (
    .sys_clk(sys_clk), .rstn(rstn), .man_clock_bit(man_clock_bit),
    .man_select_bit(man_select_bit), .man_write_bit(man_write_bit),
    .eeprom_select_in(eeprom_select_in), .eeprom_read_data(eeprom_read_data),
    .eeprom_serial_clock(eeprom_serial_clock), .eeprom_select_out(eeprom_select_out),
    .eeprom_select_oe(eeprom_select_oe), .eeprom_write_data(eeprom_write_data),
    .man_read_bit_ff(man_read_bit_ff), .vendor_id_ff(vendor_id_ff),
    .subsys_vendor_id_ff(subsys_vendor_id_ff), .eeprom_present_ff(eeprom_present_ff),
    .load_done_ff(load_done_ff));
`default_nettype wire

/* File: eeprom_word_model.sv */
// Purpose: Serial word EEPROM answering read commands.
// Assumes: Select high active; bits taken at clock rise.
// Notes:   Data line toggles each cycle while deselected.
`timescale 1ns/1ps
`default_nettype none
module eeprom_word_model #(parameter logic [15:0] W0 = 16'h0000, W1 = 16'h0000) (
    input wire logic sys_clk,
    input wire logic sclk,
    input wire logic select,
    input wire logic din,
    output var logic dout = 1'b0
);
    logic       sclk_d = 1'b0;
    logic [4:0] n      = 5'h00;
    logic [8:0] cmd    = 9'h000;
    logic [15:0] word;
    assign word = (cmd[5:0] == 6'h00) ? W0 : (cmd[5:0] == 6'h01) ? W1 : 16'hFFFF;
    always @(posedge sys_clk) begin
        sclk_d <= sclk;
        if (!select) begin
            n    <= 5'h00;
            dout <= ~dout;
        end else if (sclk && !sclk_d) begin
            n <= n + 5'h01;
            if (n < 5'h09) cmd <= {cmd[7:0], din};
            if (n >= 5'h0A && n < 5'h1A)
                dout <= (cmd[8:6] == 3'h6) ? word[5'h19 - n] : ~dout;
        end
    end
endmodule // eeprom_word_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench of the EEPROM identification loader.
// Assumes: Divided clock half period shortened to four cycles.
// Notes:   Select pin level is resolved from drive and pull.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] VID = 16'hA5C3;
    localparam logic [15:0] SID = 16'h3C5A;
    logic sys_clk = 0, rstn = 0, mclk = 0, msel = 0, mwr = 0, pull = 1;
    logic sclk, sel_o, sel_oe, wdat, rbit, pres, done, rdat;
    logic [15:0] vid, sid;
    wire logic sel_pin = sel_oe ? sel_o : pull;
    int miscompares = 0, n_checks = 0;
    initial forever #50 sys_clk = ~sys_clk;
    serial_eeprom_id_loader #(.HALF_CYCLES(4)) DUT (.sys_clk(sys_clk), .rstn(rstn),
        .man_clock_bit(mclk), .man_select_bit(msel), .man_write_bit(mwr),
        .eeprom_select_in(sel_pin), .eeprom_read_data(rdat), .eeprom_serial_clock(sclk),
        .eeprom_select_out(sel_o), .eeprom_select_oe(sel_oe), .eeprom_write_data(wdat),
        .man_read_bit_ff(rbit), .vendor_id_ff(vid), .subsys_vendor_id_ff(sid),
        .eeprom_present_ff(pres), .load_done_ff(done));
    eeprom_word_model #(.W0(VID), .W1(SID)) PEER (.sys_clk(sys_clk), .sclk(sclk),
        .select(sel_o & sel_oe), .din(wdat), .dout(rdat));
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rst(logic p);
        @(posedge sys_clk) rstn <= 0;
        pull <= p;
        repeat (6) @(posedge sys_clk);
        rstn <= 1;
    endtask
    task automatic t_load;
        @(posedge sys_clk) {mwr, msel, mclk} <= 3'h5;
        rst(1);
        for (int i = 0; i < 1000 && done !== 1'b1; i++) @(negedge sys_clk);
        chk("done", 1, done);
        chk("present", 1, pres);
        chk("vendor", VID, vid);
        chk("subsys", SID, sid);
    endtask
    task automatic t_manual;
        logic r;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk) {mwr, msel, mclk} <= i[2:0];
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk) r = rdat;
            @(negedge sys_clk);
            chk("clock", i[0], sclk);
            chk("select", {i[1], 1'b1}, {sel_o, sel_oe});
            chk("write", i[2], wdat);
            chk("read", r, rbit);
        end
    endtask
    task automatic t_absent;
        rst(0);
        repeat (20) @(negedge sys_clk);
        chk("present", 0, pres);
        chk("done", 1, done);
        chk("ids", 0, vid | sid);
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        t_load;
        t_manual;
        t_absent;
        t_manual;
        results;
    end
    initial begin
        #300000;
        miscompares++;
        results;
    end
endmodule // testbench
`default_nettype wire
